//--- logic/bcd_calendar_clock.sv
// BCD calendar clock with alarm, periodic event, entry checks and APB registers
//
// Register access over APB and the register offsets were decided locally.
module bcd_calendar_clock
  import calendar_clock_pkg::*;
#(
  parameter int SLOW_DIVIDE = SLOW_HZ
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic slow_reference_clock_tick,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic interrupt_request
);

  function automatic logic [6:0] bcd_to_bin(input logic [7:0] v);
    return 7'(({3'b000, v[7:4]} * 7'd10) + {3'b000, v[3:0]});
  endfunction

  function automatic logic [7:0] bin_to_bcd(input logic [6:0] b);
    logic [6:0] tens;
    logic [6:0] units;
    tens = b / 7'd10;
    units = b % 7'd10;
    return {tens[3:0], units[3:0]};
  endfunction

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    return (v[3:0] >= 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction

  function automatic logic in_bcd(input logic [7:0] v, input logic [7:0] lo,
                                  input logic [7:0] hi);
    return v[3:0] <= 4'h9 && v[7:4] <= 4'h9 && v >= lo && v <= hi;
  endfunction

  function automatic logic [7:0] month_days(input logic [7:0] m, input logic [7:0] y);
    logic [6:0] yb;
    yb = bcd_to_bin(y);
    unique case (m)
      8'h02: month_days = (yb[1:0] == 2'b00) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_days = 8'h30;
      default: month_days = 8'h31;
    endcase
  endfunction

  function automatic logic hour_ok(input logic [7:0] h, input logic pm, input logic mode12);
    return mode12 ? in_bcd(h, 8'h01, 8'h12) : (in_bcd(h, 8'h00, 8'h23) && !pm);
  endfunction

  function automatic logic [7:0] hour_to_24(input logic [7:0] h, input logic pm);
    if (h == 8'h12) begin
      return pm ? 8'h12 : 8'h00;
    end
    return pm ? bin_to_bcd(bcd_to_bin(h) + 7'd12) : h;
  endfunction

  function automatic logic cal_ok(input logic [7:0] c, input logic [7:0] y, input logic [7:0] mo,
                                  input logic [7:0] d, input logic [2:0] dy, input logic pers);
    logic cent_ok;
    cent_ok = pers ? in_bcd(c, 8'h13, 8'h14) : in_bcd(c, 8'h19, 8'h20);
    return cent_ok && in_bcd(y, 8'h00, 8'h99) && in_bcd(mo, 8'h01, 8'h12)
           && in_bcd(d, 8'h01, 8'h31) && d <= month_days(mo, y)
           && in_bcd({5'h00, dy}, 8'h01, 8'h07);
  endfunction

  function automatic logic time_ok(input logic [7:0] s, input logic [7:0] m, input logic [7:0] h);
    return in_bcd(s, 8'h00, 8'h59) && in_bcd(m, 8'h00, 8'h59) && in_bcd(h, 8'h00, 8'h23);
  endfunction

  trim_if trim();

  logic time_req;
  logic cal_req;
  logic time_req_d;
  logic cal_req_d;
  periodic_event_t event_sel;
  logic hour12;
  logic persian;
  logic [7:0] sec;
  logic [7:0] min;
  logic [7:0] hour;
  logic [7:0] cent;
  logic [7:0] year;
  logic [7:0] month;
  logic [7:0] date;
  logic [2:0] day;
  logic [7:0] al_sec;
  logic [7:0] al_min;
  logic [7:0] al_hour;
  logic [7:0] al_month;
  logic [7:0] al_date;
  logic [4:0] al_en;
  logic [2:0] al_en_time;
  logic [1:0] al_en_cal;
  logic [ST_W-1:0] status;
  logic [ST_W-1:0] irq_mask;
  logic [3:0] not_valid;
  logic time_changed;

  logic wr;
  logic mapped;
  logic [7:0] w_sec;
  logic [7:0] w_min;
  logic [7:0] w_hour;
  logic [7:0] w_cent;
  logic [7:0] w_year;
  logic [7:0] w_month;
  logic [7:0] w_date;
  logic [2:0] w_day;
  logic w_time_ok;
  logic w_cal_ok;
  logic w_talarm_ok;
  logic w_calarm_ok;
  logic time_write;
  logic cal_write;
  logic tick_time;
  logic sec_wrap;
  logic min_wrap;
  logic hour_wrap;
  logic day_step;
  logic alarm_match;
  logic period_event;
  logic [ST_W-1:0] status_set;
  logic [ST_W-1:0] status_clr;
  logic [31:0] read_value;

  assign trim.slow_tick = slow_reference_clock_tick;
  // Enables live in two registers, one per alarm register, so each has a single writer
  assign al_en = {al_en_cal, al_en_time};
  assign pready = 1'b1;
  assign wr = psel && penable && pwrite;
  assign mapped = paddr[1:0] == 2'b00 && paddr <= OFS_VALID_ENTRY;
  assign pslverr = psel && penable && !mapped;
  // Combinational so a flag is seen the cycle it is set
  assign interrupt_request = |(status & irq_mask);

  second_prescaler #(.DIVIDE(SLOW_DIVIDE)) prescaler (
    .clock(clock),
    .rst(rst),
    .trim(trim)
  );

  // Write-side field decode and entry checks
  always_comb begin
    w_sec = {1'b0, pwdata[TM_SEC_LSB +: 7]};
    w_min = {1'b0, pwdata[TM_MIN_LSB +: 7]};
    w_hour = {2'b00, pwdata[TM_HOUR_LSB +: 6]};
    w_cent = {1'b0, pwdata[CL_CENT_LSB +: 7]};
    w_year = pwdata[CL_YEAR_LSB +: 8];
    w_month = {3'b000, pwdata[CL_MONTH_LSB +: 5]};
    w_date = {2'b00, pwdata[CL_DATE_LSB +: 6]};
    w_day = pwdata[CL_DAY_LSB +: 3];
    w_time_ok = in_bcd(w_sec, 8'h00, 8'h59) && in_bcd(w_min, 8'h00, 8'h59)
                && hour_ok(w_hour, pwdata[TM_PM], hour12);
    w_cal_ok = cal_ok(w_cent, w_year, w_month, w_date, w_day, persian);
    w_talarm_ok = w_time_ok;
    w_calarm_ok = in_bcd(w_month, 8'h01, 8'h12) && in_bcd(w_date, 8'h01, 8'h31);
    // Counters are only writable while their counting is held
    time_write = wr && paddr == OFS_TIME_OF_DAY && time_req;
    cal_write = wr && paddr == OFS_CALENDAR_VALUE && cal_req;
  end

  // Counting chain
  always_comb begin
    sec_wrap = sec == 8'h59;
    min_wrap = min == 8'h59;
    hour_wrap = hour == 8'h23;
    tick_time = trim.one_hz && !time_req;
    day_step = tick_time && sec_wrap && min_wrap && hour_wrap && !cal_req;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sec <= 8'h00;
      min <= 8'h00;
      hour <= 8'h00;
    end else if (time_write && w_time_ok) begin
      sec <= w_sec;
      min <= w_min;
      hour <= hour12 ? hour_to_24(w_hour, pwdata[TM_PM]) : w_hour;
    end else if (tick_time) begin
      sec <= sec_wrap ? 8'h00 : bcd_inc(sec);
      if (sec_wrap) begin
        min <= min_wrap ? 8'h00 : bcd_inc(min);
        if (min_wrap) begin
          hour <= hour_wrap ? 8'h00 : bcd_inc(hour);
        end
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cent <= {1'b0, CAL_RESET[CL_CENT_LSB +: 7]};
      year <= CAL_RESET[CL_YEAR_LSB +: 8];
      month <= {3'b000, CAL_RESET[CL_MONTH_LSB +: 5]};
      date <= {2'b00, CAL_RESET[CL_DATE_LSB +: 6]};
      day <= CAL_RESET[CL_DAY_LSB +: 3];
    end else if (cal_write && w_cal_ok) begin
      cent <= w_cent;
      year <= w_year;
      month <= w_month;
      date <= w_date;
      day <= w_day;
    end else if (day_step) begin
      day <= (day == 3'd7) ? 3'd1 : day + 3'd1;
      if (date >= month_days(month, year)) begin
        date <= 8'h01;
        if (month == 8'h12) begin
          month <= 8'h01;
          if (year == 8'h99) begin
            year <= 8'h00;
            cent <= bcd_inc(cent);
          end else begin
            year <= bcd_inc(year);
          end
        end else begin
          month <= bcd_inc(month);
        end
      end else begin
        date <= bcd_inc(date);
      end
    end
  end

  // Control and mode registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      time_req <= 1'b0;
      cal_req <= 1'b0;
      event_sel <= EV_MINUTE;
    end else if (wr && paddr == OFS_UPDATE_CONTROL) begin
      time_req <= pwdata[CR_TIME_REQ];
      cal_req <= pwdata[CR_CAL_REQ];
      event_sel <= periodic_event_t'(pwdata[CR_EVSEL_LSB +: 2]);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      time_req_d <= 1'b0;
      cal_req_d <= 1'b0;
    end else begin
      time_req_d <= time_req;
      cal_req_d <= cal_req;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hour12 <= 1'b0;
      persian <= 1'b0;
      trim.negative <= 1'b0;
      trim.correction <= 7'h00;
      trim.wide_range <= 1'b0;
    end else if (wr && paddr == OFS_CLOCK_MODE) begin
      hour12 <= pwdata[MR_HOUR12];
      persian <= pwdata[MR_PERSIAN];
      trim.negative <= pwdata[MR_TRIM_NEG];
      trim.correction <= pwdata[MR_TRIM_CORR_LSB +: 7];
      trim.wide_range <= pwdata[MR_TRIM_WIDE];
    end
  end

  // Alarm fields, stored with the hour in 24-hour form
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      al_sec <= 8'h00;
      al_min <= 8'h00;
      al_hour <= 8'h00;
      al_en_time <= 3'b000;
    end else if (wr && paddr == OFS_TIME_MATCH && w_talarm_ok) begin
      al_sec <= w_sec;
      al_min <= w_min;
      al_hour <= hour12 ? hour_to_24(w_hour, pwdata[TM_PM]) : w_hour;
      al_en_time <= {pwdata[AL_HOUR_EN], pwdata[AL_MIN_EN], pwdata[AL_SEC_EN]};
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      al_month <= {3'b000, CAL_MATCH_RESET[CL_MONTH_LSB +: 5]};
      al_date <= {2'b00, CAL_MATCH_RESET[CL_DATE_LSB +: 6]};
      al_en_cal <= 2'b00;
    end else if (wr && paddr == OFS_CALENDAR_MATCH && w_calarm_ok) begin
      al_month <= w_month;
      al_date <= w_date;
      al_en_cal <= {pwdata[AL_DATE_EN], pwdata[AL_MONTH_EN]};
    end
  end

  // Validity flags: set by a refused write, cleared only by an accepted one
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      not_valid <= 4'h0;
    end else begin
      if (time_write) begin
        not_valid[VE_TIME] <= !w_time_ok;
      end
      if (cal_write) begin
        not_valid[VE_CAL] <= !w_cal_ok;
      end
      if (wr && paddr == OFS_TIME_MATCH) begin
        not_valid[VE_TIME_MATCH] <= !w_talarm_ok;
      end
      if (wr && paddr == OFS_CALENDAR_MATCH) begin
        not_valid[VE_CAL_MATCH] <= !w_calarm_ok;
      end
    end
  end

  // Event detection
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      time_changed <= 1'b0;
    end else begin
      time_changed <= tick_time;
    end
  end

  always_comb begin
    // Disabled fields match anything; at least one field must be enabled
    alarm_match = (|al_en)
                  && (!al_en[0] || sec == al_sec) && (!al_en[1] || min == al_min)
                  && (!al_en[2] || hour == al_hour) && (!al_en[3] || month == al_month)
                  && (!al_en[4] || date == al_date);
    unique case (event_sel)
      EV_MINUTE: period_event = tick_time && sec_wrap;
      EV_HOUR: period_event = tick_time && sec_wrap && min_wrap;
      EV_MIDNIGHT: period_event = tick_time && sec_wrap && min_wrap && hour_wrap;
      EV_NOON: period_event = tick_time && sec_wrap && min_wrap && hour == 8'h11;
    endcase
    status_set = '0;
    status_set[ST_ACK] = (time_req && !time_req_d) || (cal_req && !cal_req_d);
    status_set[ST_ALARM] = time_changed && alarm_match;
    status_set[ST_SEC] = trim.one_hz;
    status_set[ST_TIMEV] = period_event;
    // Continuous check of the running counters
    status_set[ST_COUNTER_VALUE_ERROR_FLAG] = !(time_ok(sec, min, hour)
                             && cal_ok(cent, year, month, date, day, persian));
    status_clr = (wr && paddr == OFS_STATUS_CLEAR) ? pwdata[ST_W-1:0] : '0;
  end

  // Set wins over a clear in the same cycle, so no event is lost
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      status <= '0;
    end else begin
      status <= (status & ~status_clr) | status_set;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_mask <= '0;
    end else if (wr && paddr == OFS_IRQ_ENABLE) begin
      irq_mask <= irq_mask | pwdata[ST_W-1:0];
    end else if (wr && paddr == OFS_IRQ_DISABLE) begin
      irq_mask <= irq_mask & ~pwdata[ST_W-1:0];
    end
  end

  // Read mux; write-only and reserved offsets read zero
  always_comb begin
    read_value = '0;
    unique case (paddr)
      OFS_UPDATE_CONTROL: begin
        read_value[CR_TIME_REQ] = time_req;
        read_value[CR_CAL_REQ] = cal_req;
        read_value[CR_EVSEL_LSB +: 2] = event_sel;
      end
      OFS_CLOCK_MODE: begin
        read_value[MR_HOUR12] = hour12;
        read_value[MR_PERSIAN] = persian;
        read_value[MR_TRIM_NEG] = trim.negative;
        read_value[MR_TRIM_CORR_LSB +: 7] = trim.correction;
        read_value[MR_TRIM_WIDE] = trim.wide_range;
      end
      OFS_TIME_OF_DAY: begin
        read_value[TM_SEC_LSB +: 7] = sec[6:0];
        read_value[TM_MIN_LSB +: 7] = min[6:0];
        read_value[TM_HOUR_LSB +: 6] = hour[5:0];
        read_value[TM_PM] = hour12 && hour >= 8'h12;
      end
      OFS_CALENDAR_VALUE: begin
        read_value[CL_CENT_LSB +: 7] = cent[6:0];
        read_value[CL_YEAR_LSB +: 8] = year;
        read_value[CL_MONTH_LSB +: 5] = month[4:0];
        read_value[CL_DAY_LSB +: 3] = day;
        read_value[CL_DATE_LSB +: 6] = date[5:0];
      end
      OFS_TIME_MATCH: begin
        read_value[TM_SEC_LSB +: 7] = al_sec[6:0];
        read_value[AL_SEC_EN] = al_en[0];
        read_value[TM_MIN_LSB +: 7] = al_min[6:0];
        read_value[AL_MIN_EN] = al_en[1];
        read_value[TM_HOUR_LSB +: 6] = al_hour[5:0];
        read_value[TM_PM] = hour12 && al_hour >= 8'h12;
        read_value[AL_HOUR_EN] = al_en[2];
      end
      OFS_CALENDAR_MATCH: begin
        read_value[CL_MONTH_LSB +: 5] = al_month[4:0];
        read_value[AL_MONTH_EN] = al_en[3];
        read_value[CL_DATE_LSB +: 6] = al_date[5:0];
        read_value[AL_DATE_EN] = al_en[4];
      end
      OFS_EVENT_STATUS: read_value[ST_W-1:0] = status;
      OFS_IRQ_MASK: read_value[ST_W-1:0] = irq_mask;
      OFS_VALID_ENTRY: read_value[3:0] = not_valid;
      default: read_value = '0;
    endcase
  end

  // Read data is captured in the setup cycle and stands through the access cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= read_value;
    end
  end

endmodule // bcd_calendar_clock

//--- logic/calendar_clock_pkg.sv
// Shared constants, register map and field layout of the calendar clock
package calendar_clock_pkg;

  // Register byte offsets on the APB
  localparam logic [7:0] OFS_UPDATE_CONTROL = 8'h00;
  localparam logic [7:0] OFS_CLOCK_MODE = 8'h04;
  localparam logic [7:0] OFS_TIME_OF_DAY = 8'h08;
  localparam logic [7:0] OFS_CALENDAR_VALUE = 8'h0c;
  localparam logic [7:0] OFS_TIME_MATCH = 8'h10;
  localparam logic [7:0] OFS_CALENDAR_MATCH = 8'h14;
  localparam logic [7:0] OFS_EVENT_STATUS = 8'h18;
  localparam logic [7:0] OFS_STATUS_CLEAR = 8'h1c;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h20;
  localparam logic [7:0] OFS_IRQ_DISABLE = 8'h24;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
  localparam logic [7:0] OFS_VALID_ENTRY = 8'h2c;

  // Update control register fields
  localparam int CR_TIME_REQ = 0;
  localparam int CR_CAL_REQ = 1;
  localparam int CR_EVSEL_LSB = 8;

  // Clock mode register fields
  localparam int MR_HOUR12 = 0;
  localparam int MR_PERSIAN = 1;
  localparam int MR_TRIM_NEG = 4;
  localparam int MR_TRIM_CORR_LSB = 8;
  localparam int MR_TRIM_WIDE = 15;

  // Time of day and time match fields
  localparam int TM_SEC_LSB = 0;
  localparam int TM_MIN_LSB = 8;
  localparam int TM_HOUR_LSB = 16;
  localparam int TM_PM = 22;
  localparam int AL_SEC_EN = 7;
  localparam int AL_MIN_EN = 15;
  localparam int AL_HOUR_EN = 23;

  // Calendar value and calendar match fields
  localparam int CL_CENT_LSB = 0;
  localparam int CL_YEAR_LSB = 8;
  localparam int CL_MONTH_LSB = 16;
  localparam int CL_DAY_LSB = 21;
  localparam int CL_DATE_LSB = 24;
  localparam int AL_MONTH_EN = 23;
  localparam int AL_DATE_EN = 31;

  // Values after reset
  localparam logic [31:0] CAL_RESET = 32'h01a11020;
  localparam logic [31:0] CAL_MATCH_RESET = 32'h01010000;

  // Event status bits, shared by status, clear and interrupt mask
  localparam int ST_ACK = 0;
  localparam int ST_ALARM = 1;
  localparam int ST_SEC = 2;
  localparam int ST_TIMEV = 3;
  localparam int ST_COUNTER_VALUE_ERROR_FLAG = 5;
  localparam int ST_W = 6;

  // Valid entry register bits
  localparam int VE_TIME = 0;
  localparam int VE_CAL = 1;
  localparam int VE_TIME_MATCH = 2;
  localparam int VE_CAL_MATCH = 3;

  // Slow reference and calibration
  localparam int SLOW_HZ = 32768;
  // 128 slow periods is about 3.9 ms, i.e. 3906 ppm of one second
  localparam int TRIM_STEP_SLOW = 128;
  localparam int LOW_RANGE_SCALE = 20;

  typedef enum logic [1:0] {
    EV_MINUTE = 2'b00,
    EV_HOUR = 2'b01,
    EV_MIDNIGHT = 2'b10,
    EV_NOON = 2'b11
  } periodic_event_t;

endpackage

//--- logic/trim_if.sv
// Carrier between the register block and the calibrated one-second divider
interface trim_if;
  logic slow_tick;
  logic wide_range;
  logic negative;
  logic [6:0] correction;
  logic one_hz;

  modport control(output slow_tick, output wide_range, output negative, output correction,
                  input one_hz);
  modport divider(input slow_tick, input wide_range, input negative, input correction,
                  output one_hz);
endinterface

//--- logic/second_prescaler.sv
// Calibrated divider from the slow reference ticks down to one pulse per second
module second_prescaler
  import calendar_clock_pkg::*;
#(
  parameter int DIVIDE = SLOW_HZ
) (
  input wire logic clock,
  input wire logic rst,
  trim_if.divider trim
);

  if (DIVIDE <= 2 * TRIM_STEP_SLOW || DIVIDE + TRIM_STEP_SLOW > 131071) begin : bad_divide
    $error("second_prescaler: DIVIDE out of range");
  end

  localparam logic [16:0] NOMINAL = 17'(DIVIDE);
  localparam logic [16:0] STEP = 17'(TRIM_STEP_SLOW);

  logic [16:0] phase;
  logic [11:0] seconds_since;
  logic adjusting;
  logic [16:0] limit;
  logic [11:0] interval;
  logic second_end;

  // Settings are read live, so a new trim takes effect at the next second
  always_comb begin
    if (!adjusting) begin
      limit = NOMINAL;
    end else if (trim.negative) begin
      limit = NOMINAL + STEP;
    end else begin
      limit = NOMINAL - STEP;
    end
    if (trim.wide_range) begin
      interval = {5'h00, trim.correction} + 12'h001;
    end else begin
      interval = 12'(({5'h00, trim.correction} + 12'h001) * 12'(LOW_RANGE_SCALE));
    end
    second_end = trim.slow_tick && (phase >= limit - 17'h00001);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phase <= '0;
    end else if (trim.slow_tick) begin
      phase <= second_end ? '0 : phase + 17'h00001;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      trim.one_hz <= 1'b0;
    end else begin
      trim.one_hz <= second_end;
    end
  end

  // One period in every interval seconds is stretched or shortened
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      seconds_since <= '0;
      adjusting <= 1'b0;
    end else if (second_end) begin
      if (trim.correction == 7'h00) begin
        seconds_since <= '0;
        adjusting <= 1'b0;
      end else if (seconds_since >= interval - 12'h001) begin
        seconds_since <= '0;
        adjusting <= 1'b1;
      end else begin
        seconds_since <= seconds_since + 12'h001;
        adjusting <= 1'b0;
      end
    end
  end

endmodule // second_prescaler

//--- testbench/bcd_calendar_clock_asserts.sv
// Port-level checks of the calendar clock, bound to its top module
module bcd_calendar_clock_asserts
  import calendar_clock_pkg::*;
#(parameter int SLOW_DIVIDE = 300) (
  input wire logic clock,
  input wire logic rst,
  input wire logic slow_reference_clock_tick,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic interrupt_request
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  logic rd;
  assign rd = psel && penable && !pwrite;
  chk_ready_high: assert property (pready)
    else $error("pready low");
  chk_bad_addr: assert property (rd && paddr > 8'h2c |-> pslverr && prdata == '0)
    else $error("unmapped read not refused");
  chk_good_addr: assert property (psel && !penable && paddr < 8'h30 && paddr[1:0] == 2'b00
    ##1 penable |-> !pslverr)
    else $error("mapped access refused");
  chk_min_sec_bcd: assert property (rd && paddr == OFS_TIME_OF_DAY |-> prdata[6:4] < 3'h6 &&
    prdata[3:0] < 4'ha && prdata[14:12] < 3'h6 && prdata[11:8] < 4'ha)
    else $error("bad minute or second");
  chk_hour_range: assert property (rd && paddr == OFS_TIME_OF_DAY |-> prdata[21:16] <= 6'h23 &&
    prdata[19:16] < 4'ha)
    else $error("bad hour");
  chk_date_range: assert property (rd && paddr == OFS_CALENDAR_VALUE |->
    prdata[29:24] inside {[6'h01:6'h31]} && prdata[20:16] inside {[5'h01:5'h12]})
    else $error("bad date or month");
  chk_status_spare: assert property (rd && paddr == OFS_EVENT_STATUS |-> prdata[31:6] == '0)
    else $error("status spare bits set");
  chk_irq_masked: assert property (rd && paddr == OFS_IRQ_MASK && prdata == '0 |->
    !interrupt_request)
    else $error("interrupt with empty mask");
endmodule // bcd_calendar_clock_asserts

bind bcd_calendar_clock bcd_calendar_clock_asserts #(.SLOW_DIVIDE(SLOW_DIVIDE))
  bcd_calendar_clock_asserts_inst (.clock(clock), .rst(rst),
  .slow_reference_clock_tick(slow_reference_clock_tick), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .interrupt_request(interrupt_request));

//--- testbench/bcd_calendar_clock_test.sv
// Self-checking bench for the calendar clock
module bcd_calendar_clock_test
  import calendar_clock_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [31:0] v; logic [31:0] m;} note_t;
  note_t notes[$];
  logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pready, pslverr, irq;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, seed = 32'h8044, prdata;
  logic [31:0] bad [10] = '{32'h0, 32'h6000, 32'h240000, 32'h400000, 32'h01a11021,
    32'h32a11020, 32'h01b31020, 32'h01011020, 32'h30a21020, 32'h29a21020};
  int err_count = 0, checks_done = 0, cycles = 0;
  always #20 clock = ~clock;
  bcd_calendar_clock #(.SLOW_DIVIDE(300)) bcd_calendar_clock_inst (.clock(clock), .rst(rst),
    .slow_reference_clock_tick(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .interrupt_request(irq));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task give_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m = '1);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w)
      notes.push_back('{d & m, m});
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  // Clear every flag, then sleep until the one-second event interrupts
  task sec_wait;
    apb(1'b1, OFS_STATUS_CLEAR, 32'h3f);
    while (irq !== 1'b1)
      @(posedge clock);
    @(posedge clock);
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles > 5000) begin
      err_count++;
      give_verdict();
    end else if (psel && penable && !pwrite) begin
      checks_done++;
      if ((prdata & notes[0].m) !== notes[0].v) begin
        err_count++;
        $display("BAD reg %h expected %h seen %h", paddr, notes[0].v, prdata);
      end
      void'(notes.pop_front());
    end
  end
  initial begin
    logic [7:0] a;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    seed = xs(seed);
    bad[0] = {25'h0, 2'b11, seed[4:0]};
    apb(1'b1, 8'h30, seed);
    apb(1'b0, 8'h30, 32'h0);
    apb(1'b0, OFS_CALENDAR_VALUE, CAL_RESET);
    apb(1'b0, OFS_CALENDAR_MATCH, CAL_MATCH_RESET);
    apb(1'b0, OFS_EVENT_STATUS, 32'h0, 32'h2b);
    $display("reset test done");
    apb(1'b1, OFS_TIME_OF_DAY, 32'h123456);
    apb(1'b0, OFS_TIME_OF_DAY, 32'h0);
    apb(1'b1, OFS_UPDATE_CONTROL, 32'h3);
    apb(1'b0, OFS_EVENT_STATUS, 32'h1, 32'h1);
    apb(1'b1, OFS_STATUS_CLEAR, 32'h1);
    for (int i = 0; i < 10; i++) begin
      a = i < 4 ? OFS_TIME_OF_DAY : OFS_CALENDAR_VALUE;
      apb(1'b1, a, bad[i]);
      apb(1'b0, OFS_VALID_ENTRY, i < 4 ? 32'h1 : 32'h3, 32'hf);
      apb(1'b0, a, i < 4 ? 32'h0 : CAL_RESET);
    end
    apb(1'b1, OFS_TIME_OF_DAY, 32'h235958);
    apb(1'b1, OFS_CALENDAR_VALUE, 32'h28421220);
    apb(1'b0, OFS_VALID_ENTRY, 32'h0, 32'hf);
    apb(1'b1, OFS_TIME_MATCH, 32'h0);
    apb(1'b1, OFS_TIME_MATCH, 32'h80);
    apb(1'b0, OFS_TIME_MATCH, 32'h80);
    apb(1'b1, OFS_IRQ_ENABLE, 32'h4);
    apb(1'b0, OFS_IRQ_MASK, 32'h4);
    $display("entry test done");
    sec_wait;
    apb(1'b1, OFS_UPDATE_CONTROL, 32'h200);
    sec_wait;
    apb(1'b0, OFS_TIME_OF_DAY, 32'h235959);
    apb(1'b0, OFS_TIME_OF_DAY, 32'h235959);
    apb(1'b0, OFS_EVENT_STATUS, 32'h4, 32'he);
    sec_wait;
    apb(1'b0, OFS_TIME_OF_DAY, 32'h0);
    apb(1'b0, OFS_CALENDAR_VALUE, 32'h29621220);
    apb(1'b0, OFS_EVENT_STATUS, 32'he, 32'he);
    apb(1'b1, OFS_UPDATE_CONTROL, 32'h2);
    apb(1'b0, OFS_EVENT_STATUS, 32'h1, 32'h1);
    sec_wait;
    apb(1'b0, OFS_TIME_OF_DAY, 32'h1);
    apb(1'b0, OFS_CALENDAR_VALUE, 32'h29621220);
    apb(1'b1, OFS_IRQ_DISABLE, 32'h4);
    apb(1'b0, OFS_IRQ_MASK, 32'h0);
    $display("count test done");
    give_verdict();
  end
endmodule // bcd_calendar_clock_test
